// ===== bench/agen_mem_model.sv
// Data memory model answering the pointer byte reads of the block
`timescale 1ns/1ps
`default_nettype none
module agen_mem_model
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Read port driven by the block
  input  wire logic        mem_rd_in,
  input  wire logic [15:0] mem_addr_in,
  input  wire logic [3:0]  lat_in,
  output logic             mem_rdy_out,
  output logic      [7:0]  mem_data_out
);
  logic [3:0] cnt_ff;    // Wait cycles spent on the current byte
  logic [3:0] nxt_cnt;   // Next wait count
  logic       nxt_rdy;   // Next answer strobe
  logic [7:0] nxt_data;  // Next data line value

  // Answer after lat_in idle cycles; between answers the data line
  // toggles, so a stale byte can never pass for a fresh one
  always_comb
  begin
    nxt_cnt  = 4'h0;
    nxt_rdy  = 1'h0;
    nxt_data = ~mem_data_out;
    if (mem_rd_in && !mem_rdy_out)
    begin
      if (cnt_ff == lat_in)
      begin
        nxt_rdy  = 1'h1;
        nxt_data = mem_addr_in[15:8] ^ mem_addr_in[7:0] ^ 8'h3c; // Stored byte
      end
      else
        nxt_cnt = cnt_ff + 4'h1;
    end
  end

  // State registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_ff       <= 4'h0;
      mem_rdy_out  <= 1'h0;
      mem_data_out <= 8'h5a;
    end
    else
    begin
      cnt_ff       <= nxt_cnt;
      mem_rdy_out  <= nxt_rdy;
      mem_data_out <= nxt_data;
    end
  end
endmodule
`default_nettype wire

// ===== bench/operand_address_generator_test.sv
// Self-checking bench of the operand address generator
`timescale 1ns/1ps
`default_nettype none
module operand_address_generator_test;
  // Design inputs, each with a value at time zero
  logic        clk_sys_in = 1'h0, rst_n_in = 1'h0, psel_in = 1'h0;
  logic        penable_in = 1'h0, pwrite_in = 1'h0, req_valid_in = 1'h0;
  logic        req_rmw_in = 1'h0, page_ext_in = 1'h0, carry_in = 1'h1;
  logic [11:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [3:0]  req_mode_in = '0, lat = '0;
  logic [2:0]  req_reg_sel_in = '0;
  logic [7:0]  op1_in = '0, op2_in = '0, acc_in = 8'h11, x_in = 8'h22;
  logic [7:0]  y_in = 8'h33, program_status_word_in = 8'h44;
  // Design outputs and captured answers
  logic [31:0] prdata_out, rd;
  logic        pready_out, pslverr_out, req_ready_out, result_valid_out;
  logic        result_is_mem_out, result_fault_out, mem_rd_out;
  logic        mem_rdy_in, er;
  logic [15:0] result_addr_out, mem_addr_out;
  logic [7:0]  result_data_out, mem_data_in;
  int          mismatches = 0, check_count = 0;

  operand_address_generator u_dut (.*);
  agen_mem_model u_mem (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .mem_rd_in(mem_rd_out), .mem_addr_in(mem_addr_out), .lat_in(lat),
    .mem_rdy_out(mem_rdy_in), .mem_data_out(mem_data_in));

  // 40 MHz clock
  always #12.5 clk_sys_in = ~clk_sys_in;

  // Verdict and end of run
  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  // A wait that used up its bound is a hang: count it and stop
  task automatic give_up(input int n, input int lim);
    if (n >= lim)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask

  // Memory byte content, as the model stores it
  function automatic logic [7:0] mdat(input logic [15:0] a);
    return a[15:8] ^ a[7:0] ^ 8'h3c;
  endfunction

  // One APB transfer; answer left in rd and er
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    psel_in    <= 1'h1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    n = 0;
    do
      @(posedge clk_sys_in);
    while (pready_out !== 1'h1 && ++n < 20);
    give_up(n, 20);
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
  endtask

  // One operand request; returns where the result or fault shows
  task automatic req(input logic [3:0] m, input logic [2:0] s,
                     input logic r, input logic p,
                     input logic [7:0] a, input logic [7:0] b);
    int n;
    @(posedge clk_sys_in);
    req_mode_in    <= m;
    req_reg_sel_in <= s;
    req_rmw_in     <= r;
    page_ext_in    <= p;
    op1_in         <= a;
    op2_in         <= b;
    req_valid_in   <= 1'h1;
    n = 0;
    do
      @(negedge clk_sys_in);
    while (req_ready_out !== 1'h1 && ++n < 50);
    give_up(n, 50);
    @(posedge clk_sys_in);
    req_valid_in <= 1'h0;
    n = 0;
    do
      @(negedge clk_sys_in);
    while (result_valid_out !== 1'h1 && result_fault_out !== 1'h1
           && ++n < 50);
    give_up(n, 50);
  endtask

  // Register reset value, read back and an unmapped address
  task automatic t_regs;
    apb(1'h0, agen_pkg::PAGE_ADDR, '0);
    chk(rd, {24'h0, agen_pkg::PAGE_RST});
    apb(1'h1, agen_pkg::PAGE_ADDR, 32'hffff_ffa5);
    apb(1'h0, agen_pkg::PAGE_ADDR, '0);
    chk(rd, 32'ha5);
    apb(1'h1, 12'hffc, 32'h1234);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask

  // Register, immediate and direct page forms, plus refusals
  task automatic t_direct;
    logic [7:0] v [5];
    v = '{acc_in, x_in, y_in, {7'h0, carry_in}, program_status_word_in};
    for (int i = 0; i < 5; i++)
    begin
      req(agen_pkg::MODE_REG, 3'(i), 1'h0, 1'h0, 8'h00, 8'h00);
      chk({result_is_mem_out, result_data_out}, {24'h0, v[i]});
    end
    req(agen_pkg::MODE_REG, 3'h5, 1'h0, 1'h0, 8'h00, 8'h00);
    chk(result_fault_out, 32'h1);
    req(4'hb, 3'h0, 1'h0, 1'h0, 8'h00, 8'h00);
    chk(result_fault_out, 32'h1);
    req(agen_pkg::MODE_IMM, 3'h0, 1'h0, 1'h0, 8'h3c, 8'h00);
    chk({result_is_mem_out, result_data_out}, 32'h3c);
    req(agen_pkg::MODE_PG, 3'h0, 1'h0, 1'h1, 8'h7e, 8'h00);
    chk({result_is_mem_out, result_addr_out}, 32'h1_a57e);
    req(agen_pkg::MODE_PG, 3'h0, 1'h0, 1'h0, 8'h7e, 8'h00);
    chk({result_is_mem_out, result_addr_out}, 32'h1_007e);
    req(agen_pkg::MODE_XREG, 3'h0, 1'h0, 1'h1, 8'h00, 8'h00);
    chk(result_addr_out, 32'ha522);
    req(agen_pkg::MODE_PG_X, 3'h0, 1'h0, 1'h0, 8'hf0, 8'h00);
    chk(result_addr_out, 32'h0012);
    req(agen_pkg::MODE_PG_Y, 3'h0, 1'h0, 1'h1, 8'h10, 8'h00);
    chk(result_addr_out, 32'ha543);
  endtask

  // Absolute addresses and the data RAM limit of read-modify-write
  task automatic t_abs;
    req(agen_pkg::MODE_ABS, 3'h0, 1'h0, 1'h1, 8'h12, 8'hfe);
    chk({result_valid_out, result_addr_out}, 32'h1_fe12);
    req(agen_pkg::MODE_ABS, 3'h0, 1'h1, 1'h0, 8'hff, 8'h00);
    chk({result_valid_out, result_addr_out}, 32'h1_00ff);
    req(agen_pkg::MODE_ABS, 3'h0, 1'h1, 1'h0, 8'h00, 8'h01);
    chk({result_valid_out, result_fault_out}, 32'h1);
    req(agen_pkg::MODE_ABS_Y, 3'h0, 1'h0, 1'h0, 8'hf0, 8'h12);
    chk(result_addr_out, 32'h1323);
  endtask

  // Indirect pointers at a page end: pg forms wrap the high byte inside the page, [!abs] crosses into the next page
  task automatic t_ind(input logic [3:0] l);
    logic [15:0] p;
    lat = l;
    p = {mdat(16'ha500), mdat(16'ha5ff)};
    req(agen_pkg::MODE_IND_Y, 3'h0, 1'h0, 1'h1, 8'hff, 8'h00);
    chk(result_addr_out, p + 16'(y_in));
    req(agen_pkg::MODE_IND_X, 3'h0, 1'h0, 1'h1, 8'hdd, 8'h00);
    chk(result_addr_out, p);
    req(agen_pkg::MODE_IND_AB, 3'h0, 1'h0, 1'h0, 8'hff, 8'h12);
    chk(result_addr_out, {mdat(16'h1300), mdat(16'h12ff)});
  endtask

  // Main sequence: reset, then every scenario
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk({result_valid_out, req_ready_out, mem_rd_out}, 32'h2);
    t_regs();
    t_direct();
    t_abs();
    t_ind(4'h0);
    t_ind(4'h3);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== src/agen_pkg.sv
// Shared constants, types and helpers of the operand address generator
`default_nettype none
package agen_pkg;

  // Bus geometry
  localparam int unsigned APB_AW  = 12;           // APB byte address width
  localparam int unsigned APB_DW  = 32;           // APB data width

  // Register indexes; byte address is four times the index
  localparam logic [7:0]  PAGE_IDX    = 8'he1;    // Page select register
  localparam logic [7:0]  STATUS_IDX  = 8'h10;    // Status readback
  localparam logic [7:0]  RAM_TOP_IDX = 8'h11;    // Last data RAM address
  localparam logic [11:0] PAGE_ADDR    = {2'h0, PAGE_IDX, 2'h0};
  localparam logic [11:0] STATUS_ADDR  = {2'h0, STATUS_IDX, 2'h0};
  localparam logic [11:0] RAM_TOP_ADDR = {2'h0, RAM_TOP_IDX, 2'h0};

  // Values after reset, and the page used without page extension
  localparam logic [7:0]  PAGE_RST    = 8'h00;
  localparam logic [15:0] RAM_TOP_RST = 16'h00ff;
  localparam logic [7:0]  ZERO_PAGE   = 8'h00;

  // Status register fields
  localparam int unsigned ST_ADDR_LSB = 0;        // Last address, 16 bits
  localparam int unsigned ST_FAULT    = 16;       // Sticky fault, write 1 clears
  localparam int unsigned ST_BUSY     = 17;       // Pointer fetch running

  // Operand location modes, as decoded from the instruction
  typedef enum logic [3:0] {
    MODE_REG    = 4'h0,   // Internal register
    MODE_IMM    = 4'h1,   // Second byte is the value
    MODE_PG     = 4'h2,   // pg
    MODE_ABS    = 4'h3,   // !abs
    MODE_XREG   = 4'h4,   // {X}
    MODE_PG_X   = 4'h5,   // pg+X
    MODE_PG_Y   = 4'h6,   // pg+Y
    MODE_ABS_Y  = 4'h7,   // !abs+Y
    MODE_IND_X  = 4'h8,   // [pg+X]
    MODE_IND_Y  = 4'h9,   // [pg]+Y
    MODE_IND_AB = 4'ha    // [!abs]
  } addr_mode_e;

  // Internal register picked in register mode
  typedef enum logic [2:0] {
    SEL_ACC   = 3'h0,
    SEL_X     = 3'h1,
    SEL_Y     = 3'h2,
    SEL_CARRY = 3'h3,
    SEL_STW   = 3'h4
  } reg_sel_e;

  // Address inside a page
  function automatic logic [15:0] page_addr(input logic [7:0] page,
                                            input logic [7:0] offset);
    return {page, offset};
  endfunction

  // Offset sum that wraps inside the page
  function automatic logic [7:0] wrap_add(input logic [7:0] a,
                                          input logic [7:0] b);
    return a + b;
  endfunction

endpackage
`default_nettype wire

// ===== src/agen_ptr_fetch.sv
// Two-byte pointer fetch from data memory for indirect modes
`timescale 1ns/1ps
`default_nettype none
module agen_ptr_fetch
(
  // Clock and synchronised reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // Start with the two byte addresses of the pointer
  input  wire logic        start_in,
  input  wire logic [15:0] lo_addr_in,
  input  wire logic [15:0] hi_addr_in,
  // Data memory read port
  output logic             mem_rd_out,
  output logic      [15:0] mem_addr_out,
  input  wire logic        mem_rdy_in,
  input  wire logic [7:0]  mem_data_in,
  // Result
  output logic             done_out,
  output logic      [15:0] ptr_out
);

  typedef enum logic [1:0] {
    PF_IDLE = 2'h0,
    PF_LO   = 2'h1,
    PF_HI   = 2'h2
  } fetch_state_e;

  fetch_state_e state_ff, nxt_state;   // Sequencer
  logic         rd_ff,    nxt_rd;      // Read request, held until the high byte is ready
  logic [15:0]  addr_ff,  nxt_addr;    // Address on the port
  logic [15:0]  hi_ff,    nxt_hi;      // Saved high byte address
  logic [15:0]  ptr_ff,   nxt_ptr;     // Assembled pointer
  logic         done_ff,  nxt_done;    // One-cycle completion

  // Low byte first, then high byte
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rd    = rd_ff;
    nxt_addr  = addr_ff;
    nxt_hi    = hi_ff;
    nxt_ptr   = ptr_ff;
    nxt_done  = 1'b0;
    case (state_ff)
      PF_IDLE:
        if (start_in)
        begin
          nxt_state = PF_LO;
          nxt_rd    = 1'b1;
          nxt_addr  = lo_addr_in;
          nxt_hi    = hi_addr_in;
        end
      PF_LO:
        if (mem_rdy_in)
        begin
          nxt_ptr[7:0] = mem_data_in;
          nxt_addr     = hi_ff;
          nxt_state    = PF_HI;
        end
      PF_HI:
        if (mem_rdy_in)
        begin
          nxt_ptr[15:8] = mem_data_in;
          nxt_rd        = 1'b0;
          nxt_done      = 1'b1;
          nxt_state     = PF_IDLE;
        end
      default:
      begin
        nxt_state = PF_IDLE;
        nxt_rd    = 1'b0;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= PF_IDLE;
      rd_ff    <= 1'b0;
      addr_ff  <= 16'h0000;
      hi_ff    <= 16'h0000;
      ptr_ff   <= 16'h0000;
      done_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rd_ff    <= nxt_rd;
      addr_ff  <= nxt_addr;
      hi_ff    <= nxt_hi;
      ptr_ff   <= nxt_ptr;
      done_ff  <= nxt_done;
    end
  end

  assign mem_rd_out   = rd_ff;
  assign mem_addr_out = addr_ff;
  assign done_out     = done_ff;
  assign ptr_out      = ptr_ff;

endmodule
`default_nettype wire

// ===== src/agen_regs.sv
// APB register slave: page select, data RAM limit and status
`timescale 1ns/1ps
`default_nettype none
module agen_regs
(
  // Clock and synchronised reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Settings to the address logic
  output logic      [7:0]  ram_page_select_out,
  output logic      [15:0] ram_top_out,
  // Status from the address logic
  input  wire logic [15:0] last_addr_in,
  input  wire logic        fault_evt_in,
  input  wire logic        busy_in
);

  logic [7:0]  pgs_ff,    nxt_pgs;      // Page select
  logic [15:0] top_ff,    nxt_top;      // Highest data RAM address
  logic        fault_ff,  nxt_fault;    // Sticky fault
  logic [31:0] rdata_ff,  nxt_rdata;    // Read data
  logic        ready_ff,  nxt_ready;    // Access phase answer
  logic        err_ff,    nxt_err;      // Unmapped address
  logic        setup;
  logic        wr_take;
  logic        mapped;

  // Answer in the access cycle right after setup: no wait states
  always_comb
  begin
    setup     = psel_in && !penable_in;
    wr_take   = psel_in && penable_in && ready_ff && pwrite_in;
    mapped    = (paddr_in == agen_pkg::PAGE_ADDR) ||
                (paddr_in == agen_pkg::STATUS_ADDR) ||
                (paddr_in == agen_pkg::RAM_TOP_ADDR);
    nxt_ready = setup;
    nxt_err   = setup && !mapped;
    nxt_rdata = 32'h0000_0000;
    nxt_pgs   = pgs_ff;
    nxt_top   = top_ff;
    nxt_fault = fault_ff;
    // Reads are captured at setup; unmapped reads return zero
    if (setup && !pwrite_in)
    begin
      case (paddr_in)
        agen_pkg::PAGE_ADDR:    nxt_rdata = {24'h00_0000, pgs_ff};
        agen_pkg::RAM_TOP_ADDR: nxt_rdata = {16'h0000, top_ff};
        agen_pkg::STATUS_ADDR:  nxt_rdata = {14'h0000, busy_in, fault_ff,
                                             last_addr_in};
        default:                nxt_rdata = 32'h0000_0000;
      endcase
    end
    // Writes take effect at the completing edge only
    if (wr_take)
    begin
      case (paddr_in)
        agen_pkg::PAGE_ADDR:    nxt_pgs = pwdata_in[7:0];
        agen_pkg::RAM_TOP_ADDR: nxt_top = pwdata_in[15:0];
        agen_pkg::STATUS_ADDR:
          if (pwdata_in[agen_pkg::ST_FAULT])
            nxt_fault = 1'b0;
        default:                nxt_pgs = pgs_ff;
      endcase
    end
    // A new fault beats a clear in the same cycle
    if (fault_evt_in)
      nxt_fault = 1'b1;
  end

  // Register stage
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pgs_ff   <= agen_pkg::PAGE_RST;
      top_ff   <= agen_pkg::RAM_TOP_RST;
      fault_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
    end
    else
    begin
      pgs_ff   <= nxt_pgs;
      top_ff   <= nxt_top;
      fault_ff <= nxt_fault;
      rdata_ff <= nxt_rdata;
      ready_ff <= nxt_ready;
      err_ff   <= nxt_err;
    end
  end

  assign prdata_out          = rdata_ff;
  assign pready_out          = ready_ff;
  assign pslverr_out         = err_ff;
  assign ram_page_select_out = pgs_ff;
  assign ram_top_out         = top_ff;

endmodule
`default_nettype wire

// ===== src/operand_address_generator.sv
// Operand address generator top: mode decode, page logic, result stage
`timescale 1ns/1ps
`default_nettype none
//Contract
//- Eleven operand modes, selected by instruction
//- Register mode reads A, X, Y, C, status
//- Immediate mode: second byte is the value
//- Page extension set: address is page:immediate
//- Direct page: one byte inside current page
//- Absolute: second byte low, third byte high
//- Absolute three-byte ops reach whole space
//- Absolute read-modify-write stays in data RAM; code checks !abs only, !abs+Y read-modify-write is not held to ram_top
module operand_address_generator
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Request from the execute stage
  input  wire logic        req_valid_in,
  output logic             req_ready_out,
  input  wire logic [3:0]  req_mode_in,
  input  wire logic [2:0]  req_reg_sel_in,
  input  wire logic        req_rmw_in,
  input  wire logic        page_ext_in,
  input  wire logic [7:0]  op1_in,
  input  wire logic [7:0]  op2_in,
  // Core registers
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  x_in,
  input  wire logic [7:0]  y_in,
  input  wire logic        carry_in,
  input  wire logic [7:0]  program_status_word_in,
  // Result
  output logic             result_valid_out,
  output logic             result_is_mem_out,
  output logic      [15:0] result_addr_out,
  output logic      [7:0]  result_data_out,
  output logic             result_fault_out,
  // Pointer read port to data memory
  output logic             mem_rd_out,
  output logic      [15:0] mem_addr_out,
  input  wire logic        mem_rdy_in,
  input  wire logic [7:0]  mem_data_in
);

  typedef enum logic [0:0] {
    GEN_IDLE  = 1'h0,
    GEN_FETCH = 1'h1
  } gen_state_e;

  // Reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Settings from the register file
  logic [7:0]  ram_page_select;
  logic [15:0] ram_top;

  // Pointer fetch hookup
  logic        ptr_start;
  logic [15:0] ptr_lo_addr;
  logic [15:0] ptr_hi_addr;
  logic        ptr_done;
  logic [15:0] ptr_value;

  // Result stage state
  gen_state_e  state_ff,  nxt_state;   // Idle or waiting for a pointer
  logic        ready_ff,  nxt_ready;   // Accepting requests
  logic        valid_ff,  nxt_valid;   // One-cycle result strobe
  logic        is_mem_ff, nxt_is_mem;  // Address rather than value
  logic [15:0] addr_ff,   nxt_addr;    // Formed address
  logic [7:0]  data_ff,   nxt_data;    // Operand value
  logic        fault_ff,  nxt_fault;   // Request refused
  logic        post_y_ff, nxt_post_y;  // Add Y after the pointer
  logic [7:0]  y_ff,      nxt_y;       // Y captured at the request

  // Decode helpers
  logic        take;
  logic [7:0]  page;
  logic [15:0] abs_addr;
  logic [7:0]  pg_x;

  agen_regs u_regs
  (
    .clk_sys_in          (clk_sys_in),
    .rst_n_in            (rst_sync_ff),
    .psel_in             (psel_in),
    .penable_in          (penable_in),
    .pwrite_in           (pwrite_in),
    .paddr_in            (paddr_in),
    .pwdata_in           (pwdata_in),
    .prdata_out          (prdata_out),
    .pready_out          (pready_out),
    .pslverr_out         (pslverr_out),
    .ram_page_select_out (ram_page_select),
    .ram_top_out         (ram_top),
    .last_addr_in        (addr_ff),
    .fault_evt_in        (fault_ff),
    .busy_in             (state_ff == GEN_FETCH)
  );

  agen_ptr_fetch u_ptr
  (
    .clk_sys_in   (clk_sys_in),
    .rst_n_in     (rst_sync_ff),
    .start_in     (ptr_start),
    .lo_addr_in   (ptr_lo_addr),
    .hi_addr_in   (ptr_hi_addr),
    .mem_rd_out   (mem_rd_out),
    .mem_addr_out (mem_addr_out),
    .mem_rdy_in   (mem_rdy_in),
    .mem_data_in  (mem_data_in),
    .done_out     (ptr_done),
    .ptr_out      (ptr_value)
  );

  // Mode decode and address forming; one request at a time
  always_comb
  begin
    take        = req_valid_in && ready_ff;
    // Without page extension the zero page is used, page select ignored
    page        = page_ext_in ? ram_page_select : agen_pkg::ZERO_PAGE;
    abs_addr    = {op2_in, op1_in};
    pg_x        = agen_pkg::wrap_add(op1_in, x_in);
    nxt_state   = state_ff;
    nxt_ready   = ready_ff;
    nxt_valid   = 1'b0;
    nxt_is_mem  = is_mem_ff;
    nxt_addr    = addr_ff;
    nxt_data    = data_ff;
    nxt_fault   = 1'b0;
    nxt_post_y  = post_y_ff;
    nxt_y       = y_ff;
    ptr_start   = 1'b0;
    ptr_lo_addr = 16'h0000;
    ptr_hi_addr = 16'h0000;
    case (state_ff)
      GEN_IDLE:
        if (take)
        begin
          nxt_valid  = 1'b1;
          nxt_is_mem = 1'b1;
          nxt_data   = 8'h00;
          case (req_mode_in)
            agen_pkg::MODE_REG:
            begin
              nxt_is_mem = 1'b0;
              case (req_reg_sel_in)
                agen_pkg::SEL_ACC:   nxt_data = acc_in;
                agen_pkg::SEL_X:     nxt_data = x_in;
                agen_pkg::SEL_Y:     nxt_data = y_in;
                agen_pkg::SEL_CARRY: nxt_data = {7'h00, carry_in};
                agen_pkg::SEL_STW:   nxt_data = program_status_word_in;
                default:             nxt_fault = 1'b1;
              endcase
            end
            agen_pkg::MODE_IMM:
            begin
              // Value straight from the instruction, no memory cycle
              nxt_is_mem = 1'b0;
              nxt_data   = op1_in;
              nxt_addr   = agen_pkg::page_addr(page, op1_in);
            end
            agen_pkg::MODE_PG:
              nxt_addr = agen_pkg::page_addr(page, op1_in);
            agen_pkg::MODE_ABS:
            begin
              nxt_addr = abs_addr;
              // Only read-modify-write is held to data RAM
              if (req_rmw_in && (abs_addr > ram_top))
                nxt_fault = 1'b1;
            end
            agen_pkg::MODE_XREG:
              nxt_addr = agen_pkg::page_addr(page, x_in);
            agen_pkg::MODE_PG_X:
              nxt_addr = agen_pkg::page_addr(page, pg_x);
            agen_pkg::MODE_PG_Y:
              nxt_addr = agen_pkg::page_addr(page,
                           agen_pkg::wrap_add(op1_in, y_in));
            agen_pkg::MODE_ABS_Y:
              nxt_addr = abs_addr + {8'h00, y_in};
            agen_pkg::MODE_IND_X, agen_pkg::MODE_IND_Y,
            agen_pkg::MODE_IND_AB:
            begin
              // Pointer bytes come from memory; result waits for them
              nxt_valid  = 1'b0;
              nxt_ready  = 1'b0;
              nxt_state  = GEN_FETCH;
              nxt_y      = y_in;
              ptr_start  = 1'b1;
              nxt_post_y = (req_mode_in == agen_pkg::MODE_IND_Y);
              if (req_mode_in == agen_pkg::MODE_IND_AB)
              begin
                ptr_lo_addr = abs_addr;
                ptr_hi_addr = abs_addr + 16'h0001;
              end
              else if (req_mode_in == agen_pkg::MODE_IND_X)
              begin
                // Pair stays inside the page
                ptr_lo_addr = agen_pkg::page_addr(page, pg_x);
                ptr_hi_addr = agen_pkg::page_addr(page,
                                agen_pkg::wrap_add(pg_x, 8'h01));
              end
              else
              begin
                ptr_lo_addr = agen_pkg::page_addr(page, op1_in);
                ptr_hi_addr = agen_pkg::page_addr(page,
                                agen_pkg::wrap_add(op1_in, 8'h01));
              end
            end
            default:
              nxt_fault = 1'b1;
          endcase
          // A refused request produces a fault strobe instead of a result
          if (nxt_fault)
          begin
            nxt_valid  = 1'b0;
            nxt_is_mem = 1'b0;
          end
        end
      GEN_FETCH:
        if (ptr_done)
        begin
          nxt_valid  = 1'b1;
          nxt_is_mem = 1'b1;
          nxt_ready  = 1'b1;
          nxt_state  = GEN_IDLE;
          nxt_addr   = post_y_ff ? ptr_value + {8'h00, y_ff} : ptr_value;
        end
      default:
      begin
        nxt_state = GEN_IDLE;
        nxt_ready = 1'b1;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff  <= GEN_IDLE;
      ready_ff  <= 1'b1;
      valid_ff  <= 1'b0;
      is_mem_ff <= 1'b0;
      addr_ff   <= 16'h0000;
      data_ff   <= 8'h00;
      fault_ff  <= 1'b0;
      post_y_ff <= 1'b0;
      y_ff      <= 8'h00;
    end
    else
    begin
      state_ff  <= nxt_state;
      ready_ff  <= nxt_ready;
      valid_ff  <= nxt_valid;
      is_mem_ff <= nxt_is_mem;
      addr_ff   <= nxt_addr;
      data_ff   <= nxt_data;
      fault_ff  <= nxt_fault;
      post_y_ff <= nxt_post_y;
      y_ff      <= nxt_y;
    end
  end

  assign req_ready_out     = ready_ff;
  assign result_valid_out  = valid_ff;
  assign result_is_mem_out = is_mem_ff;
  assign result_addr_out   = addr_ff;
  assign result_data_out   = data_ff;
  assign result_fault_out  = fault_ff;

  // Checks on the result stage
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_sync_ff);

  sequence take_s(logic [3:0] m);
    req_valid_in && req_ready_out && (req_mode_in == m);
  endsequence

  sequence mem_result_s;
    result_valid_out && result_is_mem_out && !result_fault_out;
  endsequence

  a_mode_answer: assert property (
    (req_valid_in && req_ready_out) |=>
      (result_valid_out || result_fault_out || !req_ready_out))
    else $error("request taken without result, fault or fetch");

  a_reg_select: assert property (
    (take_s(agen_pkg::MODE_REG) and (req_reg_sel_in == agen_pkg::SEL_ACC))
      |=> result_valid_out && !result_is_mem_out &&
          (result_data_out == $past(acc_in)))
    else $error("register mode did not return the accumulator");

  a_imm_value: assert property (
    take_s(agen_pkg::MODE_IMM) |=> result_valid_out &&
      !result_is_mem_out && (result_data_out == $past(op1_in)))
    else $error("immediate value not the second byte");

  a_page_ext: assert property (
    (take_s(agen_pkg::MODE_PG) and page_ext_in) |=> mem_result_s ##0
      (result_addr_out == {$past(ram_page_select), $past(op1_in)}))
    else $error("extended page address not page and operand");

  a_pg_offset: assert property (
    take_s(agen_pkg::MODE_PG) |=>
      (result_addr_out[7:0] == $past(op1_in)))
    else $error("direct page offset wrong");

  a_abs_order: assert property (
    take_s(agen_pkg::MODE_ABS) |=> (result_addr_out == $past({op2_in,
                                                             op1_in})))
    else $error("absolute byte order wrong");

  a_abs_whole: assert property (
    (take_s(agen_pkg::MODE_ABS) and !req_rmw_in) |=> mem_result_s)
    else $error("absolute access refused");

  a_rmw_ram: assert property (
    (take_s(agen_pkg::MODE_ABS) and req_rmw_in and
      ({op2_in, op1_in} > ram_top)) |=>
      result_fault_out && !result_valid_out ##1 !result_fault_out)
    else $error("read-modify-write outside RAM not refused");

  a_zero_page: assert property (
    (take_s(agen_pkg::MODE_PG_X) and !page_ext_in) |=>
      mem_result_s ##0 (result_addr_out[15:8] == 8'h00))
    else $error("page extension clear but page not zero");

endmodule
`default_nettype wire
